// [logic/fwpin_pkg.sv]
package fwpin_pkg;

    // ------------------------------------------------------------------
    // Clock rates and divider counts
    // ------------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ     = 100_000_000;
    localparam int unsigned INTERFACE_CLOCK_SLOW_MHZ = 30;
    localparam int unsigned INTERFACE_CLOCK_FAST_MHZ = 48;
    localparam int unsigned HZ_PER_MHZ     = 1_000_000;
    localparam int unsigned HALF_SLOW_RAW  =
        SYS_CLK_HZ / (2 * INTERFACE_CLOCK_SLOW_MHZ * HZ_PER_MHZ);
    localparam int unsigned HALF_FAST_RAW  =
        SYS_CLK_HZ / (2 * INTERFACE_CLOCK_FAST_MHZ * HZ_PER_MHZ);
    localparam int unsigned DIV_W          = 4;
    // A half period never drops below one system cycle
    localparam logic [DIV_W-1:0] HALF_SLOW_CYC =
        (HALF_SLOW_RAW < 1) ? 4'h1 : HALF_SLOW_RAW[DIV_W-1:0];
    localparam logic [DIV_W-1:0] HALF_FAST_CYC =
        (HALF_FAST_RAW < 1) ? 4'h1 : HALF_FAST_RAW[DIV_W-1:0];

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CFG_ADDR    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_WAVE_ADDR   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] REG_PORTE_ADDR  = 8'h0c;

    // interface_config fields
    localparam int unsigned CFG_W           = 8;
    localparam int unsigned CFG_CLK_INT_BIT = 7;
    localparam int unsigned CFG_FAST_BIT    = 6;
    localparam int unsigned CFG_CLK_OUT_BIT = 5;
    localparam int unsigned CFG_INV_BIT     = 4;
    localparam int unsigned CFG_MODE_LSB    = 0;
    localparam int unsigned MODE_W          = 2;
    localparam logic [CFG_W-1:0] CFG_RST    = 8'h80;

    // Waveform drive levels and flag defaults
    localparam int unsigned CTL_N            = 6;
    localparam int unsigned FLAG_N           = 3;
    localparam logic [CTL_N-1:0]  WAVE_RST   = 6'h3f;
    localparam logic [FLAG_N-1:0] FLAG_RST   = 3'h7;

    // Status and port E fields
    localparam int unsigned READY_N         = 3;
    localparam int unsigned STAT_READY_LSB  = 0;
    localparam int unsigned STAT_INTERFACE_CLOCK_BIT  = 3;
    localparam int unsigned STAT_SEL_LSB    = 4;
    localparam int unsigned PE_OUT_BIT      = 0;
    localparam int unsigned PE_DRV_BIT      = 1;
    localparam int unsigned PE_IN_BIT       = 2;

    // Interface mode field encodings
    typedef enum logic [MODE_W-1:0] {
        FWPIN_MODE_PORTS = 2'b00,
        FWPIN_MODE_RSVD  = 2'b01,
        FWPIN_MODE_WAVE  = 2'b10,
        FWPIN_MODE_SLAVE = 2'b11
    } fwpin_mode_type;

endpackage : fwpin_pkg

// [logic/fwpin_sync.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------------
module fwpin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : fwpin_sync

// [logic/fwpin_clkgen.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Internal interface clock divider
// ----------------------------------------------------------------------
module fwpin_clkgen (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic enable_i,
    input  wire logic fast_i,
    output logic      level_o
);

    logic [fwpin_pkg::DIV_W-1:0] cnt_q;
    logic [fwpin_pkg::DIV_W-1:0] half_cyc;

    // Rate is limited by the system clock: both settings may round
    // to the same half period at low system rates
    assign half_cyc = fast_i ? fwpin_pkg::HALF_FAST_CYC
                             : fwpin_pkg::HALF_SLOW_CYC;

    // Toggle the level every half period while enabled
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q   <= '0;
            level_o <= 1'b0;
        end
        else if (!enable_i)
        begin
            cnt_q   <= '0;
            level_o <= 1'b0;
        end
        else if (cnt_q + 4'h1 >= half_cyc)
        begin
            cnt_q   <= '0;
            level_o <= ~level_o;
        end
        else
        begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

endmodule : fwpin_clkgen

// [logic/fwpin_top.sv]
`timescale 1ns/1ns
// Functional notes
// - Ready inputs three to five are inputs only, sampled by waveform engine.
// - Interface mode field routes first three pins to control or flags.
// - Slave mode: first pin shows programmable flag of selected FIFO.
// - Slave mode: second pin shows full flag of selected FIFO.
// - Slave mode: third pin shows empty flag of selected FIFO.
// - Pins four to six only from engine; all low in reset, high after.
// - FIFO data is moved on the interface clock by both parties.
// - Interface clock times every flag, strobe and the waveform engine.
// - Clock source bit set selects internal clock, else external pin.
// - Internal clock: bit five drives pin, bit six picks 48 or 30 MHz divider; both give 50 MHz at 100 MHz.
// - Bit four inverts interface clock for either source.
// - Without clock function the pin is a port pin, floating in reset.
module fwpin_top #(
    parameter bit          HAS_INTERFACE_CLOCK = 1'b1,
    parameter int unsigned SEL_W     = 2,
    parameter int unsigned NUM_FIFO  = 4
) (
    input  wire logic                            clk_i,
    input  wire logic                            rst_n_i,
    input  wire logic [fwpin_pkg::ADDR_W-1:0]    reg_addr_i,
    input  wire logic [fwpin_pkg::DATA_W-1:0]    reg_wdata_i,
    input  wire logic                            reg_wr_i,
    input  wire logic                            reg_rd_i,
    output logic      [fwpin_pkg::DATA_W-1:0]    reg_rdata_o,
    input  wire logic                            ready_in_3_i,
    input  wire logic                            ready_in_4_i,
    input  wire logic                            ready_in_5_i,
    input  wire logic [SEL_W-1:0]                fifo_select_pins_i,
    input  wire logic [NUM_FIFO-1:0]             fifo_prog_i,
    input  wire logic [NUM_FIFO-1:0]             fifo_full_i,
    input  wire logic [NUM_FIFO-1:0]             fifo_empty_i,
    output logic                                 wave_ctrl_out_0_o,
    output logic                                 wave_ctrl_out_1_o,
    output logic                                 wave_ctrl_out_2_o,
    output logic                                 wave_ctrl_out_3_o,
    output logic                                 wave_ctrl_out_4_o,
    output logic                                 wave_ctrl_out_5_o,
    input  wire logic                            interface_clock_i,
    output logic                                 interface_clock_o,
    output logic                                 interface_clock_oe_n_o,
    output logic                                 interface_clock_rise_o
);

    // ------------------------------------------------------------------
    // Registers and internal signals
    // ------------------------------------------------------------------
    logic [fwpin_pkg::CFG_W-1:0]    cfg_q;
    logic [fwpin_pkg::CTL_N-1:0]    wave_q;
    logic                           pe_out_q;
    logic                           pe_drv_q;
    logic [fwpin_pkg::READY_N-1:0]  ready_raw;
    logic [fwpin_pkg::READY_N-1:0]  ready_sync;
    logic [fwpin_pkg::READY_N-1:0]  ready_q;
    logic [SEL_W-1:0]               sel_sync;
    logic                           ext_clk_sync;
    logic                           gen_level;
    logic                           raw_level;
    logic                           eff_level;
    logic                           eff_prev_q;
    logic                           interface_clock_rise;
    logic                           clk_internal;
    logic [fwpin_pkg::FLAG_N-1:0]   flag_q;
    logic [fwpin_pkg::FLAG_N-1:0]   flag_pick;
    logic [fwpin_pkg::CTL_N-1:0]    wave_src_q;
    logic [fwpin_pkg::CTL_N-1:0]    pin_src;
    logic [fwpin_pkg::CTL_N-1:0]    pin_q;
    logic                           slave_mode;
    logic                           clk_pin_q;
    logic                           clk_oe_n_q;
    logic                           clk_pin_d;
    logic                           clk_oe_n_d;
    fwpin_pkg::fwpin_mode_type      mode;

    assign mode = fwpin_pkg::fwpin_mode_type'(
        cfg_q[fwpin_pkg::CFG_MODE_LSB +: fwpin_pkg::MODE_W]);
    assign slave_mode = (mode == fwpin_pkg::FWPIN_MODE_SLAVE);

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------

    // Configuration and drive registers, written by software
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_q    <= fwpin_pkg::CFG_RST;
            wave_q   <= fwpin_pkg::WAVE_RST;
            pe_out_q <= 1'b0;
            pe_drv_q <= 1'b0;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                fwpin_pkg::REG_CFG_ADDR:
                    cfg_q <= reg_wdata_i[fwpin_pkg::CFG_W-1:0];
                fwpin_pkg::REG_WAVE_ADDR:
                    wave_q <= reg_wdata_i[fwpin_pkg::CTL_N-1:0];
                fwpin_pkg::REG_PORTE_ADDR:
                begin
                    pe_out_q <= reg_wdata_i[fwpin_pkg::PE_OUT_BIT];
                    pe_drv_q <= reg_wdata_i[fwpin_pkg::PE_DRV_BIT];
                end
                default: ;
            endcase
        end
    end

    // Read data in the cycle after the strobe; unmapped reads are zero
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o <= '0;
        end
        else
        begin
            reg_rdata_o <= '0;
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    fwpin_pkg::REG_CFG_ADDR:
                        reg_rdata_o[fwpin_pkg::CFG_W-1:0] <= cfg_q;
                    fwpin_pkg::REG_WAVE_ADDR:
                        reg_rdata_o[fwpin_pkg::CTL_N-1:0] <= wave_q;
                    fwpin_pkg::REG_STATUS_ADDR:
                    begin
                        reg_rdata_o[fwpin_pkg::STAT_READY_LSB +:
                            fwpin_pkg::READY_N] <= ready_q;
                        reg_rdata_o[fwpin_pkg::STAT_INTERFACE_CLOCK_BIT] <= eff_level;
                        reg_rdata_o[fwpin_pkg::STAT_SEL_LSB +: SEL_W] <=
                            sel_sync;
                    end
                    fwpin_pkg::REG_PORTE_ADDR:
                    begin
                        reg_rdata_o[fwpin_pkg::PE_OUT_BIT] <= pe_out_q;
                        reg_rdata_o[fwpin_pkg::PE_DRV_BIT] <= pe_drv_q;
                        reg_rdata_o[fwpin_pkg::PE_IN_BIT]  <= ext_clk_sync;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    assign ready_raw = {ready_in_5_i, ready_in_4_i, ready_in_3_i};

    fwpin_sync #(
        .WIDTH (fwpin_pkg::READY_N + SEL_W + 1)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({ready_raw, fifo_select_pins_i, interface_clock_i}),
        .sync_o  ({ready_sync, sel_sync, ext_clk_sync})
    );

    // ------------------------------------------------------------------
    // Interface clock source, polarity and edge
    // ------------------------------------------------------------------

    // clock source pick
    // Without the clock function the internal divider is the reference
    assign clk_internal = !HAS_INTERFACE_CLOCK || cfg_q[fwpin_pkg::CFG_CLK_INT_BIT];

    fwpin_clkgen u_clkgen (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .enable_i (clk_internal),
        .fast_i   (cfg_q[fwpin_pkg::CFG_FAST_BIT]),
        .level_o  (gen_level)
    );

    assign raw_level = clk_internal ? gen_level : ext_clk_sync;

    assign eff_level = raw_level ^ cfg_q[fwpin_pkg::CFG_INV_BIT];

    // Edge found on the system clock; an external clock above half
    // of the system rate cannot be followed edge for edge
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            eff_prev_q <= 1'b0;
        else
            eff_prev_q <= eff_level;
    end

    assign interface_clock_rise   = eff_level && !eff_prev_q;
    assign interface_clock_rise_o = interface_clock_rise;

    // Pin drive: clock out, port pin, or input only
    always_comb
    begin
        clk_pin_d  = 1'b0;
        clk_oe_n_d = 1'b1;
        if (!HAS_INTERFACE_CLOCK)
        begin
            clk_pin_d  = pe_out_q;
            clk_oe_n_d = !pe_drv_q;
        end
        else if (clk_internal && cfg_q[fwpin_pkg::CFG_CLK_OUT_BIT])
        begin
            clk_pin_d  = eff_level;
            clk_oe_n_d = 1'b0;
        end
    end

    // Pin floats during reset
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            clk_pin_q  <= 1'b0;
            clk_oe_n_q <= 1'b1;
        end
        else
        begin
            clk_pin_q  <= clk_pin_d;
            clk_oe_n_q <= clk_oe_n_d;
        end
    end

    assign interface_clock_o      = clk_pin_q;
    assign interface_clock_oe_n_o = clk_oe_n_q;

    // ------------------------------------------------------------------
    // Ready sampling and flag selection
    // ------------------------------------------------------------------

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ready_q <= '0;
        else if (interface_clock_rise)
            ready_q <= ready_sync;
    end

    assign flag_pick = {fifo_empty_i[sel_sync],
                        fifo_full_i[sel_sync],
                        fifo_prog_i[sel_sync]};

    // flags and drive levels move only on the interface clock
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flag_q     <= fwpin_pkg::FLAG_RST;
            wave_src_q <= fwpin_pkg::WAVE_RST;
        end
        else if (interface_clock_rise)
        begin
            flag_q     <= flag_pick;
            wave_src_q <= wave_q;
        end
    end

    assign pin_src = slave_mode ?
        {wave_src_q[fwpin_pkg::CTL_N-1:fwpin_pkg::FLAG_N], flag_q} :
        wave_src_q;

    // ------------------------------------------------------------------
    // Output pin flops
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < fwpin_pkg::CTL_N; gi++)
        begin : g_pin
            // low in reset, default high after
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    pin_q[gi] <= 1'b0;
                end
                else
                begin
                    pin_q[gi] <= pin_src[gi];
                end
            end
        end
    endgenerate

    assign wave_ctrl_out_0_o = pin_q[0];
    assign wave_ctrl_out_1_o = pin_q[1];
    assign wave_ctrl_out_2_o = pin_q[2];
    assign wave_ctrl_out_3_o = pin_q[3];
    assign wave_ctrl_out_4_o = pin_q[4];
    assign wave_ctrl_out_5_o = pin_q[5];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ready_hold_edge: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !interface_clock_rise |=> $stable(ready_q))
        else $error("ready sample moved without clock edge");
    a_flags_hold_edge: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !interface_clock_rise |=> $stable(flag_q) && $stable(wave_src_q))
        else $error("flag or drive moved without clock edge");
    a_route_wave_mode: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !slave_mode |=> pin_q[2:0] == $past(wave_src_q[2:0]))
        else $error("shared pins not driven by engine");
    a_prog_flag_sel: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        interface_clock_rise && slave_mode ##1 slave_mode
        |=> pin_q[0] == $past(fifo_prog_i[sel_sync], 2))
        else $error("programmable flag wrong for selected fifo");
    a_full_flag_sel: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        interface_clock_rise && slave_mode ##1 slave_mode
        |=> pin_q[1] == $past(fifo_full_i[sel_sync], 2))
        else $error("full flag wrong for selected fifo");
    a_empty_flag_sel: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        interface_clock_rise && slave_mode ##1 slave_mode
        |=> pin_q[2] == $past(fifo_empty_i[sel_sync], 2))
        else $error("empty flag wrong for selected fifo");
    a_upper_from_engine: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        interface_clock_rise ##1 1 |=> pin_q[5:3] == $past(wave_q[5:3], 2))
        else $error("upper control pins not from engine");
    a_sel_change_track: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $changed(sel_sync) && interface_clock_rise |=> flag_q == $past(flag_pick))
        else $error("flags missed new fifo select");
    a_ext_clk_no_drive: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        HAS_INTERFACE_CLOCK && !clk_internal |=> interface_clock_oe_n_o)
        else $error("pin driven while clock is external");
    a_clk_out_enable: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        HAS_INTERFACE_CLOCK && clk_internal && cfg_q[fwpin_pkg::CFG_CLK_OUT_BIT]
        |=> !interface_clock_oe_n_o && interface_clock_o == $past(eff_level))
        else $error("internal clock not driven on pin");
    a_clk_invert_edge: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $stable(cfg_q) && cfg_q[fwpin_pkg::CFG_INV_BIT] && $fell(raw_level)
        |-> interface_clock_rise)
        else $error("inverted clock edge not seen");
    a_port_pin_drive: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !HAS_INTERFACE_CLOCK |=> interface_clock_oe_n_o == !$past(pe_drv_q))
        else $error("port pin drive enable wrong");

endmodule : fwpin_top

// [test/fwpin_far_model.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Far-side FIFO master: link clock, ready and select pins
// ----------------------------------------------------------------------
module fwpin_far_model (
    input  wire logic       run_i,
    input  wire logic [1:0] sel_i,
    input  wire logic [2:0] rdy_i,
    output logic            link_clk_o,
    output logic [1:0]      sel_o,
    output logic [2:0]      rdy_o
);
    // link clock, still and low between frames
    initial
    begin
        link_clk_o = 1'b0;
        sel_o = 2'h0;
        rdy_o = 3'h0;
        forever
        begin
            #80;
            link_clk_o = run_i ? ~link_clk_o : 1'b0;
        end
    end

    // pins move on the falling edge, far from sampling
    always @(negedge link_clk_o)
    begin
        sel_o <= sel_i;
        rdy_o <= rdy_i;
    end
endmodule : fwpin_far_model

// [test/test_fwpin_top.sv]
`timescale 1ns/1ns
module test_fwpin_top;
    logic        clk_i;
    logic        rst_n_i;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] v;
    logic        wr, rd, run, lclk, pin, ck_o, oe_n, rise;
    logic        ck_p, oe_p;
    logic [1:0]  sel, sel_p;
    logic [2:0]  rdy, rdy_p;
    logic [3:0]  prog, full, empty;
    logic [5:0]  ctl;
    int          n_errors;
    int          num_checks;

    // Pin level: device drives only while its enable is low
    assign pin = oe_n ? lclk : ck_o;

    initial
    begin
        clk_i = 1'b0;
        forever
            #5 clk_i = ~clk_i;
    end

    fwpin_top fwpin_top_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .ready_in_3_i(rdy_p[0]),
        .ready_in_4_i(rdy_p[1]), .ready_in_5_i(rdy_p[2]),
        .fifo_select_pins_i(sel_p), .fifo_prog_i(prog),
        .fifo_full_i(full), .fifo_empty_i(empty),
        .wave_ctrl_out_0_o(ctl[0]), .wave_ctrl_out_1_o(ctl[1]),
        .wave_ctrl_out_2_o(ctl[2]), .wave_ctrl_out_3_o(ctl[3]),
        .wave_ctrl_out_4_o(ctl[4]), .wave_ctrl_out_5_o(ctl[5]),
        .interface_clock_i(pin), .interface_clock_o(ck_o),
        .interface_clock_oe_n_o(oe_n), .interface_clock_rise_o(rise));

    // Variant without the clock function: the pin is a port pin
    fwpin_top #(.HAS_INTERFACE_CLOCK(1'b0)) fwpin_top_port_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(), .ready_in_3_i(rdy_p[0]),
        .ready_in_4_i(rdy_p[1]), .ready_in_5_i(rdy_p[2]),
        .fifo_select_pins_i(sel_p), .fifo_prog_i(prog),
        .fifo_full_i(full), .fifo_empty_i(empty),
        .wave_ctrl_out_0_o(), .wave_ctrl_out_1_o(),
        .wave_ctrl_out_2_o(), .wave_ctrl_out_3_o(),
        .wave_ctrl_out_4_o(), .wave_ctrl_out_5_o(),
        .interface_clock_i(lclk), .interface_clock_o(ck_p),
        .interface_clock_oe_n_o(oe_p), .interface_clock_rise_o());

    fwpin_far_model fwpin_far_model_inst (
        .run_i(run), .sel_i(sel), .rdy_i(rdy),
        .link_clk_o(lclk), .sel_o(sel_p), .rdy_o(rdy_p));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // Count interface clock rises, bounded; then let capture reach the pins
    task automatic wait_rise(input int n);
        int k;
        k = 0;
        for (int t = 0; t < 3000 && k < n; t++)
        begin
            @(posedge clk_i);
            #1;
            if (rise === 1'b1)
                k++;
        end
        if (k < n)
        begin
            n_errors++;
            report_and_stop();
        end
        repeat (2) @(posedge clk_i);
        #1;
    endtask : wait_rise

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        chk("ctl in reset", 32'h0, ctl);
        @(posedge clk_i);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk("ctl after reset", 32'h3f, ctl);
        rd_reg(8'h00, v);
        chk("cfg reset", 32'h80, v);
        rd_reg(8'h10, v);
        chk("unmapped", 32'h0, v);
        $display("reset test done");
    endtask : t_reset

    // Every select value, external clock, distinct flag patterns
    task automatic t_slave;
        @(posedge clk_i);
        run   <= 1'b1;
        prog  <= 4'h5;
        full  <= 4'h3;
        empty <= 4'h9;
        wr_reg(8'h00, 32'h03);
        for (int s = 0; s < 4; s++)
        begin
            sel <= s[1:0];
            wait_rise(3);
            chk("prog", {31'h0, prog[s]}, ctl[0]);
            chk("full", {31'h0, full[s]}, ctl[1]);
            chk("empty", {31'h0, empty[s]}, ctl[2]);
            chk("engine pins", 32'h7, ctl[5:3]);
        end
        $display("slave test done");
    endtask : t_slave

    task automatic t_wave;
        wr_reg(8'h00, 32'h02);
        wr_reg(8'h04, 32'h15);
        rdy <= 3'h5;
        wait_rise(3);
        chk("engine levels", 32'h15, ctl);
        rd_reg(8'h08, v);
        chk("ready", 32'h5, v & 32'h7);
        $display("wave test done");
    endtask : t_wave

    // Stopped external clock shows its level, inverted on request
    task automatic t_clock;
        run <= 1'b0;
        wr_reg(8'h00, 32'h10);
        repeat (4) @(posedge clk_i);
        rd_reg(8'h08, v);
        chk("inverted level", 32'h8, v & 32'h8);
        wr_reg(8'h00, 32'h00);
        repeat (4) @(posedge clk_i);
        rd_reg(8'h08, v);
        chk("plain level", 32'h0, v & 32'h8);
        wr_reg(8'h00, 32'ha0);
        wait_rise(2);
        chk("drive slow", 32'h0, oe_n);
        wr_reg(8'h00, 32'he0);
        wait_rise(2);
        chk("drive fast", 32'h0, oe_n);
        // Both rates round to one system cycle per half period here
        v[0] = ck_o;
        @(posedge clk_i);
        #1;
        chk("clock toggles", {31'h0, ~v[0]}, ck_o);
        // Inverted internal clock, pin left undriven
        wr_reg(8'h00, 32'h90);
        wait_rise(2);
        chk("no drive", 32'h1, oe_n);
        $display("clock test done");
    endtask : t_clock

    // Port pin variant drives only when enabled; main keeps the register
    task automatic t_port;
        chk("port floats", 32'h1, oe_p);
        wr_reg(8'h0c, 32'h3);
        @(posedge clk_i);
        #1;
        chk("port drive", 32'h0, oe_p);
        chk("port value", 32'h1, ck_p);
        rd_reg(8'h0c, v);
        chk("port reg", 32'h3, v);
        $display("port test done");
    endtask : t_port

    initial
    begin
        n_errors = 0;
        num_checks = 0;
        rst_n_i = 1'b0;
        {addr, wdata, wr, rd, run, sel, rdy} = '0;
        {prog, full, empty} = '0;
        #1;
        t_reset();
        t_slave();
        t_wave();
        t_clock();
        t_port();
        report_and_stop();
    end
endmodule : test_fwpin_top
